/* ccr_pkg.sv */
package ccr_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_BUCK_B_HIGH = 6'h17;
  localparam logic [5:0] IDX_BUCK_B_LOW = 6'h18;
  localparam logic [5:0] IDX_LDO_C_HIGH = 6'h19;
  localparam logic [5:0] IDX_LDO_C_LOW = 6'h1A;
  localparam logic [5:0] IDX_SUPPLY_AVG_HIGH = 6'h1B;
  localparam logic [5:0] IDX_COUNTER_CONTROL = 6'h20;
  localparam logic [5:0] IDX_COUNTER_STATUS = 6'h21;
  // Byte address fields.
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 7;
  // Control register fields.
  localparam int CTRL_PRESCALE_LSB = 0;
  localparam int CTRL_PRESCALE_MSB = 1;
  localparam int CTRL_CLEAR_BIT = 2;
  localparam int CTRL_CAL_START_BIT = 3;
  // Status register fields.
  localparam int STAT_CAL_BUSY_BIT = 0;
  localparam int STAT_CAL_HELD_BIT = 1;
  localparam int STAT_LOW_POWER_BIT = 2;
  localparam int STAT_STANDALONE_BIT = 3;
  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Calibration window timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int CAL_WINDOW_NS = 50000;
  localparam int CAL_CYCLES = CAL_WINDOW_NS / CLK_PERIOD_NS;
  localparam int CAL_CNT_W = 12;
  // Synchronised input lanes.
  localparam int LANE_PFM_B = 0;
  localparam int LANE_PFM_C = 1;
  localparam int LANE_CLK10 = 2;
  localparam int LANE_LOW_POWER = 3;
  localparam int LANE_STANDALONE = 4;
  localparam int LANES = 5;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_HELD} ccr_cal_state_t;
endpackage : ccr_pkg

/* ccr_pulse_sync.sv */
`timescale 1ns/1ps
module ccr_pulse_sync (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Asynchronous pin.
  input wire logic pin_in,
  // Synchronised level and rising edge.
  output logic level_out,
  output logic rise_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~last_q;
endmodule : ccr_pulse_sync

/* ccr_charge_counter.sv */
`timescale 1ns/1ps
module ccr_charge_counter (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control.
  input wire logic clear_in,
  input wire logic enable_in,
  input wire logic inhibit_in,
  input wire logic [1:0] prescale_in,
  // Pulse to count.
  input wire logic pulse_in,
  // Counter value.
  output logic [15:0] count_out
);
  logic [5:0] group_q;
  logic [5:0] group_d;
  logic [5:0] group_last;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic take;
  logic wrap;

  // Group size is 1, 4, 16 or 64 pulses per count.
  assign group_last = 6'((7'h01 << {prescale_in, 1'b0}) - 7'h01);
  // Pulses are dropped while the register is addressed.
  assign take = pulse_in & enable_in & ~inhibit_in;
  assign wrap = take & (group_q >= group_last);
  assign group_d = clear_in ? 6'h00 : (wrap ? 6'h00 : (take ? 6'(group_q + 6'h01) : group_q));
  assign count_d = clear_in ? ccr_pkg::COUNT_RESET : (wrap ? 16'(count_q + 16'h0001) : count_q);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      group_q <= 6'h00;
      count_q <= ccr_pkg::COUNT_RESET;
    end else begin
      group_q <= group_d;
      count_q <= count_d;
    end
  end

  assign count_out = count_q;
endmodule : ccr_charge_counter

/* ccr_charge_readout.sv */
`timescale 1ns/1ps
module ccr_charge_readout (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  // Analog front-end pins.
  input wire logic PFM_BUCK_B_IN,
  input wire logic PFM_LDO_C_IN,
  input wire logic CLK_10MHZ_IN,
  input wire logic LOW_POWER_MODE_IN,
  input wire logic LDO_C_STANDALONE_IN,
  // AXI4-Lite write address channel.
  input wire logic S_AXI_AWVALID_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  output logic S_AXI_AWREADY_OUT,
  // AXI4-Lite write data channel.
  input wire logic S_AXI_WVALID_IN,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  output logic S_AXI_WREADY_OUT,
  // AXI4-Lite write response channel.
  output logic S_AXI_BVALID_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_BREADY_IN,
  // AXI4-Lite read address channel.
  input wire logic S_AXI_ARVALID_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  output logic S_AXI_ARREADY_OUT,
  // AXI4-Lite read data channel.
  output logic S_AXI_RVALID_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  input wire logic S_AXI_RREADY_IN
);
  // Synchronised inputs.
  logic [ccr_pkg::LANES-1:0] pins;
  logic [ccr_pkg::LANES-1:0] lvl;
  logic [ccr_pkg::LANES-1:0] rise;

  assign pins = {LDO_C_STANDALONE_IN, LOW_POWER_MODE_IN, CLK_10MHZ_IN, PFM_LDO_C_IN, PFM_BUCK_B_IN};

  genvar gi;
  generate
    for (gi = 0; gi < ccr_pkg::LANES; gi++) begin : g_sync
      ccr_pulse_sync u_sync (
        .clk_in(CORE_CLK_IN),
        .resetn_in(RESETN_IN),
        .pin_in(pins[gi]),
        .level_out(lvl[gi]),
        .rise_out(rise[gi])
      );
    end
  endgenerate

  // Write channel state.
  logic awready_q;
  logic wready_q;
  logic aw_have_q;
  logic aw_have_d;
  logic w_have_q;
  logic w_have_d;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [5:0] wr_idx;
  logic wr_ok;
  logic wr_ctrl;

  assign aw_take = S_AXI_AWVALID_IN & awready_q;
  assign w_take = S_AXI_WVALID_IN & wready_q;
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign aw_have_d = (aw_have_q | aw_take) & ~wr_fire;
  assign w_have_d = (w_have_q | w_take) & ~wr_fire;
  assign bvalid_d = wr_fire | (bvalid_q & ~S_AXI_BREADY_IN);
  assign wr_idx = awaddr_q[ccr_pkg::IDX_MSB:ccr_pkg::IDX_LSB];
  assign wr_ok = (awaddr_q[1:0] == 2'h0) &&
                 ((wr_idx == ccr_pkg::IDX_COUNTER_CONTROL) || (wr_idx == ccr_pkg::IDX_COUNTER_STATUS) ||
                  ((wr_idx >= ccr_pkg::IDX_BUCK_B_HIGH) && (wr_idx <= ccr_pkg::IDX_SUPPLY_AVG_HIGH)));
  assign wr_ctrl = wr_fire & wstrb0_q & (awaddr_q[1:0] == 2'h0) & (wr_idx == ccr_pkg::IDX_COUNTER_CONTROL);

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= ccr_pkg::RESP_OKAY;
    end else begin
      awready_q <= ~aw_have_d;
      wready_q <= ~w_have_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      if (aw_take) begin
        awaddr_q <= S_AXI_AWADDR_IN;
      end
      if (w_take) begin
        wdata_q <= S_AXI_WDATA_IN;
        wstrb0_q <= S_AXI_WSTRB_IN[0];
      end
      bvalid_q <= bvalid_d;
      if (wr_fire) begin
        bresp_q <= wr_ok ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
      end
    end
  end

  // Control register and one-cycle command pulses.
  logic [1:0] prescale_q;
  logic clear_q;
  logic cal_start_q;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      prescale_q <= ccr_pkg::PRESCALE_RESET;
      clear_q <= 1'b0;
      cal_start_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        prescale_q <= wdata_q[ccr_pkg::CTRL_PRESCALE_MSB:ccr_pkg::CTRL_PRESCALE_LSB];
      end
      clear_q <= wr_ctrl & wdata_q[ccr_pkg::CTRL_CLEAR_BIT];
      cal_start_q <= wr_ctrl & wdata_q[ccr_pkg::CTRL_CAL_START_BIT];
    end
  end

  // Calibration sequencer.
  ccr_pkg::ccr_cal_state_t cal_state_q;
  ccr_pkg::ccr_cal_state_t cal_state_d;
  logic [ccr_pkg::CAL_CNT_W-1:0] cal_cnt_q;
  logic [ccr_pkg::CAL_CNT_W-1:0] cal_cnt_d;
  logic cal_run;
  logic cal_held;

  always_comb begin
    cal_state_d = cal_state_q;
    cal_cnt_d = cal_cnt_q;
    case (cal_state_q)
      ccr_pkg::CAL_IDLE: begin
        if (cal_start_q && !clear_q) begin
          cal_state_d = ccr_pkg::CAL_RUN;
          cal_cnt_d = ccr_pkg::CAL_CNT_W'(ccr_pkg::CAL_CYCLES - 1);
        end
      end
      ccr_pkg::CAL_RUN: begin
        if (cal_cnt_q == '0) begin
          cal_state_d = ccr_pkg::CAL_HELD;
        end else begin
          cal_cnt_d = cal_cnt_q - ccr_pkg::CAL_CNT_W'(1);
        end
      end
      ccr_pkg::CAL_HELD: begin
        if (clear_q) begin
          cal_state_d = ccr_pkg::CAL_IDLE;
        end
      end
      default: begin
        cal_state_d = ccr_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      cal_state_q <= ccr_pkg::CAL_IDLE;
      cal_cnt_q <= '0;
    end else begin
      cal_state_q <= cal_state_d;
      cal_cnt_q <= cal_cnt_d;
    end
  end

  assign cal_run = (cal_state_q == ccr_pkg::CAL_RUN);
  assign cal_held = (cal_state_q == ccr_pkg::CAL_HELD);

  // Read channel state.
  logic arready_q;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [5:0] rd_idx_q;
  logic ar_take;
  logic [5:0] ar_idx;
  logic ar_aligned;

  assign ar_take = S_AXI_ARVALID_IN & arready_q;
  assign ar_idx = S_AXI_ARADDR_IN[ccr_pkg::IDX_MSB:ccr_pkg::IDX_LSB];
  assign ar_aligned = (S_AXI_ARADDR_IN[1:0] == 2'h0);
  assign rvalid_d = ar_take | (rvalid_q & ~S_AXI_RREADY_IN);

  // A counter is addressed while its read is offered or its answer stands.
  logic addr_b;
  logic addr_c;
  logic inh_b;
  logic inh_c;

  assign addr_b = S_AXI_ARVALID_IN && ((ar_idx == ccr_pkg::IDX_BUCK_B_HIGH) || (ar_idx == ccr_pkg::IDX_BUCK_B_LOW));
  assign addr_c = S_AXI_ARVALID_IN && ((ar_idx == ccr_pkg::IDX_LDO_C_HIGH) || (ar_idx == ccr_pkg::IDX_LDO_C_LOW));
  assign inh_b = addr_b | (rvalid_q && ((rd_idx_q == ccr_pkg::IDX_BUCK_B_HIGH) ||
                                        (rd_idx_q == ccr_pkg::IDX_BUCK_B_LOW)));
  assign inh_c = addr_c | (rvalid_q && ((rd_idx_q == ccr_pkg::IDX_LDO_C_HIGH) ||
                                        (rd_idx_q == ccr_pkg::IDX_LDO_C_LOW)));

  // Counters.
  logic [15:0] count_b;
  logic [15:0] count_c;
  logic c_pulse;
  logic c_enable;
  logic c_clear;
  logic [1:0] c_prescale;

  ccr_charge_counter u_count_b (
    .clk_in(CORE_CLK_IN),
    .resetn_in(RESETN_IN),
    .clear_in(clear_q),
    .enable_in(lvl[ccr_pkg::LANE_LOW_POWER]),
    .inhibit_in(inh_b),
    .prescale_in(prescale_q),
    .pulse_in(rise[ccr_pkg::LANE_PFM_B]),
    .count_out(count_b)
  );

  // During calibration the C counter counts every 10 MHz edge that arrives while it is not addressed, then holds.
  assign c_pulse = cal_run ? rise[ccr_pkg::LANE_CLK10] : rise[ccr_pkg::LANE_PFM_C];
  assign c_enable = cal_run | (~cal_held & lvl[ccr_pkg::LANE_STANDALONE]);
  assign c_clear = clear_q | (cal_start_q & (cal_state_q == ccr_pkg::CAL_IDLE));
  assign c_prescale = cal_run ? ccr_pkg::PRESCALE_RESET : prescale_q;

  ccr_charge_counter u_count_c (
    .clk_in(CORE_CLK_IN),
    .resetn_in(RESETN_IN),
    .clear_in(c_clear),
    .enable_in(c_enable),
    .inhibit_in(inh_c),
    .prescale_in(c_prescale),
    .pulse_in(c_pulse),
    .count_out(count_c)
  );

  // Low-byte shadows.
  logic [7:0] shadow_b_q;
  logic [7:0] shadow_c_q;
  logic take_b_high;
  logic take_c_high;

  assign take_b_high = ar_take & ar_aligned & (ar_idx == ccr_pkg::IDX_BUCK_B_HIGH);
  assign take_c_high = ar_take & ar_aligned & (ar_idx == ccr_pkg::IDX_LDO_C_HIGH);

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      shadow_b_q <= ccr_pkg::REG_RESET;
      shadow_c_q <= ccr_pkg::REG_RESET;
    end else begin
      if (take_b_high) begin
        shadow_b_q <= count_b[7:0];
      end
      if (take_c_high) begin
        shadow_c_q <= count_c[7:0];
      end
    end
  end

  // Read data selection.
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [7:0] status_byte;

  assign status_byte = {4'h0, lvl[ccr_pkg::LANE_STANDALONE], lvl[ccr_pkg::LANE_LOW_POWER], cal_held, cal_run};

  always_comb begin
    rd_byte = ccr_pkg::REG_RESET;
    rd_hit = ar_aligned;
    case (ar_idx)
      ccr_pkg::IDX_BUCK_B_HIGH: rd_byte = count_b[15:8];
      ccr_pkg::IDX_BUCK_B_LOW: rd_byte = shadow_b_q;
      ccr_pkg::IDX_LDO_C_HIGH: rd_byte = count_c[15:8];
      ccr_pkg::IDX_LDO_C_LOW: rd_byte = shadow_c_q;
      ccr_pkg::IDX_SUPPLY_AVG_HIGH: rd_byte = ccr_pkg::REG_RESET;
      ccr_pkg::IDX_COUNTER_CONTROL: rd_byte = {6'h00, prescale_q};
      ccr_pkg::IDX_COUNTER_STATUS: rd_byte = status_byte;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= ccr_pkg::RESP_OKAY;
      rd_idx_q <= 6'h00;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= {24'h000000, rd_hit ? rd_byte : 8'h00};
        rresp_q <= rd_hit ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
        rd_idx_q <= ar_idx;
      end
    end
  end

  assign S_AXI_AWREADY_OUT = awready_q;
  assign S_AXI_WREADY_OUT = wready_q;
  assign S_AXI_BVALID_OUT = bvalid_q;
  assign S_AXI_BRESP_OUT = bresp_q;
  assign S_AXI_ARREADY_OUT = arready_q;
  assign S_AXI_RVALID_OUT = rvalid_q;
  assign S_AXI_RDATA_OUT = rdata_q;
  assign S_AXI_RRESP_OUT = rresp_q;
endmodule : ccr_charge_readout

/* ccr_readout_chk.sv */
`timescale 1ns/1ps
module ccr_readout_chk (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  // Write bus.
  input wire logic S_AXI_AWVALID_IN,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic S_AXI_WVALID_IN,
  input wire logic S_AXI_WREADY_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_BREADY_IN,
  // Read bus.
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic [1:0] S_AXI_RRESP_OUT,
  input wire logic S_AXI_RREADY_IN
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  property p_rd_ans;
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_hold;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_ar_block;
    S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("address taken during answer");
  property p_byte;
    S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000;
  endproperty
  a_byte: assert property (p_byte) else $error("upper data bits set");
  property p_err_zero;
    S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == ccr_pkg::RESP_SLVERR |-> S_AXI_RDATA_OUT == 32'h00000000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read carries data");
  property p_wr_ans;
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT |-> ##[1:2] S_AXI_BVALID_OUT;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_hold;
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer moved");
  property p_rst_quiet;
    $rose(RESETN_IN) |-> !S_AXI_RVALID_OUT && !S_AXI_BVALID_OUT && S_AXI_RDATA_OUT == 32'h00000000;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus busy after reset");
  c_read: cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);
  c_write: cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
  c_err: cover property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == ccr_pkg::RESP_SLVERR);
endmodule : ccr_readout_chk

bind ccr_charge_readout ccr_readout_chk i_chk (.*);

/* ccr_tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rstn = 1'b0, pfm_b = 1'b0, pfm_c = 1'b0, clk10 = 1'b0, low_pwr = 1'b0, alone = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [15:0] v, v2;
  int miscompares = 0, check_count = 0, cycles = 0, dv = 0;
  localparam int CAL_EDGES = ccr_pkg::CAL_CYCLES / 5;
  ccr_charge_readout i_dut (.CORE_CLK_IN(clk), .RESETN_IN(rstn), .PFM_BUCK_B_IN(pfm_b), .PFM_LDO_C_IN(pfm_c),
    .CLK_10MHZ_IN(clk10), .LOW_POWER_MODE_IN(low_pwr), .LDO_C_STANDALONE_IN(alone),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BRESP_OUT(bresp), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RREADY_IN(rready));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    dv <= (dv == 4) ? 0 : dv + 1;
    clk10 <= (dv < 2);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [5:0] idx);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic wr(input logic [5:0] idx, input logic [31:0] val);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= val;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awready) aw_done = 1'b1;
      if (wready) w_done = 1'b1;
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end
    do @(posedge clk); while (!bvalid);
    r = bresp;
  endtask : wr
  task automatic rd16(input logic [5:0] hi_idx);
    rd(hi_idx);
    v[15:8] = d[7:0];
    rd(hi_idx + 6'h01);
    v[7:0] = d[7:0];
  endtask : rd16
  task automatic pulse(input bit on_c, input int n);
    repeat (n) begin
      if (on_c) pfm_c <= 1'b1;
      else pfm_b <= 1'b1;
      repeat (3) @(posedge clk);
      pfm_c <= 1'b0;
      pfm_b <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : pulse
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      rd(ccr_pkg::IDX_BUCK_B_HIGH + 6'(i));
      chk("reset value", d, 32'h00000000);
      chk("reset resp", 32'(r), 32'(ccr_pkg::RESP_OKAY));
    end
    rd(6'h05);
    chk("unmapped resp", 32'(r), 32'(ccr_pkg::RESP_SLVERR));
    wr(ccr_pkg::IDX_LDO_C_HIGH, 32'h000000FF);
    chk("read-only write resp", 32'(r), 32'(ccr_pkg::RESP_OKAY));
    rd(ccr_pkg::IDX_LDO_C_HIGH);
    chk("read-only high", d, 32'h00000000);
    wr(6'h05, 32'h00000000);
    chk("unmapped write", 32'(r), 32'(ccr_pkg::RESP_SLVERR));
    low_pwr <= 1'b1;
    alone <= 1'b1;
    pulse(1'b1, 5);
    pulse(1'b0, 3);
    rd16(ccr_pkg::IDX_LDO_C_HIGH);
    chk("c count", 32'(v), 32'h00000005);
    rd16(ccr_pkg::IDX_BUCK_B_HIGH);
    chk("b count", 32'(v), 32'h00000003);
    rd(ccr_pkg::IDX_LDO_C_HIGH);
    pulse(1'b1, 2);
    rd(ccr_pkg::IDX_LDO_C_LOW);
    chk("c shadow", d, 32'h00000005);
    rd16(ccr_pkg::IDX_LDO_C_HIGH);
    chk("c fresh", 32'(v), 32'h00000007);
    fork
      pulse(1'b1, 1);
      begin
        repeat (2) @(posedge clk);
        rd(ccr_pkg::IDX_LDO_C_LOW);
      end
    join
    rd16(ccr_pkg::IDX_LDO_C_HIGH);
    chk("inhibited count", 32'(v), 32'h00000007);
    for (int p = 0; p < 4; p++) begin
      wr(ccr_pkg::IDX_COUNTER_CONTROL, 32'h00000004 | 32'(p));
      pulse(1'b1, 64);
      rd16(ccr_pkg::IDX_LDO_C_HIGH);
      chk("prescaled count", 32'(v), 32'd64 >> (2 * p));
    end
    rd16(ccr_pkg::IDX_LDO_C_HIGH);
    chk("saved before cal", 32'(v), 32'h00000001);
    wr(ccr_pkg::IDX_COUNTER_CONTROL, 32'h00000008);
    repeat (2600) @(posedge clk);
    rd16(ccr_pkg::IDX_LDO_C_HIGH);
    chk("cal count", 32'(v >= 16'(CAL_EDGES - 1) && v <= 16'(CAL_EDGES + 1)), 32'h00000001);
    pulse(1'b1, 3);
    v2 = v;
    rd16(ccr_pkg::IDX_LDO_C_HIGH);
    chk("cal held", 32'(v), 32'(v2));
    rd(ccr_pkg::IDX_COUNTER_STATUS);
    chk("held status", d, 32'((1 << ccr_pkg::STAT_CAL_HELD_BIT) | (1 << ccr_pkg::STAT_LOW_POWER_BIT) |
      (1 << ccr_pkg::STAT_STANDALONE_BIT)));
    wr(ccr_pkg::IDX_COUNTER_CONTROL, 32'h00000004);
    rd16(ccr_pkg::IDX_LDO_C_HIGH);
    chk("cleared", 32'(v), 32'h00000000);
    tally_and_finish();
  end
endmodule : tb
